// *** include/ddcm_pkg.sv ***
// Constants and types shared by the mode recovery control block
package ddcm_pkg;

	localparam int unsigned REF_CLK_HZ      = 25_000_000;
	localparam int unsigned RECOVERY_MS     = 2000;
	localparam int unsigned RECOVERY_CYCLES = (REF_CLK_HZ / 1000) * RECOVERY_MS;
	localparam int unsigned RECOVERY_PULSES = 128;
	localparam int unsigned INIT_PULSES     = 9;
	localparam int unsigned ADDR_W          = 7;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned PULSE_CNT_W     = 8;
	localparam int unsigned TIMER_W         = 32;

	localparam logic [3:0] BIT_IDX_LAST      = 4'h7;
	localparam logic [3:0] BIT_IDX_DONTCARE  = 4'h8;
	localparam logic [3:0] INIT_CNT_LAST     = 4'(INIT_PULSES);
	localparam logic [3:0] IDX_ZERO          = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
	localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = 8'(RECOVERY_PULSES - 1);
	// Arbitrary select code value
	localparam logic [3:0] DEV_CODE_DEFAULT  = 4'h5;

	typedef enum logic [1:0] {
		DDCM_TXO   = 2'b00,
		DDCM_TRANS = 2'b01,
		DDCM_LOCK  = 2'b11
	} ddcm_mode_e;

	typedef enum logic [1:0] {
		DDCM_DEC_IDLE  = 2'b00,
		DDCM_DEC_SHIFT = 2'b01,
		DDCM_DEC_ACK   = 2'b11,
		DDCM_DEC_DONE  = 2'b10
	} ddcm_dec_e;

endpackage : ddcm_pkg

// *** rtl/ddcm_mode_ctrl.sv ***
// Mode control for a dual-mode serial configuration memory
//
// Summary of operation
// - Serial clock falling edge leaves transmit-only mode.
// - Nine idle pulses, then MSB of byte zero.
// - Recovery variant enters transition state, acts two-wire.
// - Revert after 128 pulses or two-second timeout.
// - Valid select code locks two-wire mode permanently.
// - Locked mode ignores transmit-only clock for reads.
// - Serial clock fall restarts pulse count and timer.
// - Two-wire data sampled and driven by serial clock.
// - Data line is open drain only.
// - Transmit-only data shifts on transmit-only clock.
// - No-pin variant: transmit-only clock enables writes.
// - Pin variant: low protects, high allows writes.
// - Unconnected protect pin means protected; the code has no pull-down and uses the synchronised pin level as is.
`timescale 1ns/1ps

module ddcm_mode_ctrl
	import ddcm_pkg::*;
#(
	parameter bit                 P_RECOVERY_EN     = 1'b1,
	parameter bit                 P_HAS_WP_PIN      = 1'b0,
	parameter logic [TIMER_W-1:0] P_RECOVERY_CYCLES = TIMER_W'(RECOVERY_CYCLES),
	parameter logic [3:0]         P_DEV_CODE        = DEV_CODE_DEFAULT
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_scl,
	input  wire logic              i_sda_in,
	input  wire logic              i_transmit_only_clock,
	input  wire logic              i_write_protect_input,
	input  wire logic [DATA_W-1:0] i_rd_data,
	input  wire logic              i_engine_pull_low,
	output logic      [ADDR_W-1:0] o_rd_addr,
	output logic                   o_sda_out,
	output logic                   o_sda_oe_n,
	output logic                   o_two_wire_mode,
	output logic                   o_locked,
	output logic                   o_write_enable,
	output logic                   o_select_pulse,
	output logic                   o_select_rw
);

	// Synchronisers: stage 1, stage 2, delayed copy
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] dly_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			dly_reg   <= 4'h0;
		end else begin
			sync1_reg <= {i_write_protect_input, i_transmit_only_clock, i_sda_in, i_scl};
			sync2_reg <= sync1_reg;
			dly_reg   <= sync2_reg;
		end
	end

	logic scl_s;
	logic sda_s;
	logic transmit_only_clock_s;
	logic wp_s;
	logic scl_fall;
	logic scl_rise;
	logic transmit_only_clock_rise;
	logic start_cond;
	logic stop_cond;

	assign scl_s      = sync2_reg[0];
	assign sda_s      = sync2_reg[1];
	assign transmit_only_clock_s     = sync2_reg[2];
	assign wp_s       = sync2_reg[3];
	assign scl_fall   = dly_reg[0] & ~scl_s;
	assign scl_rise   = ~dly_reg[0] & scl_s;
	assign transmit_only_clock_rise  = ~dly_reg[2] & transmit_only_clock_s;
	assign start_cond = scl_s & dly_reg[0] & dly_reg[1] & ~sda_s;
	assign stop_cond  = scl_s & dly_reg[0] & ~dly_reg[1] & sda_s;

	ddcm_mode_e              mode_reg,     mode_next;
	ddcm_dec_e               dec_reg,      dec_next;
	logic [PULSE_CNT_W-1:0]  pulse_reg,    pulse_next;
	logic [TIMER_W-1:0]      timer_reg,    timer_next;
	logic [3:0]              init_reg,     init_next;
	logic [3:0]              bit_reg,      bit_next;
	logic [ADDR_W-1:0]       addr_reg,     addr_next;
	logic [DATA_W-1:0]       byte_reg,     byte_next;
	logic                    txo_pull_reg, txo_pull_next;
	logic [DATA_W-1:0]       sr_reg,       sr_next;
	logic [3:0]              dbit_reg,     dbit_next;
	logic                    ack_reg,      ack_next;
	logic                    sel_reg,      sel_next;
	logic                    rw_reg,       rw_next;
	logic                    pull_reg,     pull_next;
	logic                    wen_reg,      wen_next;

	logic                    two_wire;
	logic                    revert;
	logic [DATA_W-1:0]       sr_shift;

	assign two_wire = (mode_reg != DDCM_TXO);
	assign sr_shift = {sr_reg[DATA_W-2:0], sda_s};

	always_comb begin
		mode_next     = mode_reg;
		dec_next      = dec_reg;
		pulse_next    = pulse_reg;
		timer_next    = timer_reg;
		init_next     = init_reg;
		bit_next      = bit_reg;
		addr_next     = addr_reg;
		byte_next     = byte_reg;
		txo_pull_next = txo_pull_reg;
		sr_next       = sr_reg;
		dbit_next     = dbit_reg;
		ack_next      = ack_reg;
		sel_next      = 1'b0;
		rw_next       = rw_reg;
		revert        = 1'b0;

		// Select code decoder, first byte after each START
		if (two_wire) begin
			if (stop_cond) begin
				dec_next = DDCM_DEC_IDLE;
				ack_next = 1'b0;
			end else if (start_cond) begin
				dec_next  = DDCM_DEC_SHIFT;
				dbit_next = IDX_ZERO;
				ack_next  = 1'b0;
			end else begin
				case (dec_reg)
					DDCM_DEC_SHIFT: begin
						if (scl_rise) begin
							sr_next   = sr_shift;
							dbit_next = dbit_reg + 4'h1;
							if (dbit_reg == BIT_IDX_LAST) begin
								if (sr_shift[DATA_W-1 -: 4] == P_DEV_CODE) begin
									sel_next = 1'b1;
									rw_next  = sda_s;
									dec_next = DDCM_DEC_ACK;
								end else begin
									dec_next = DDCM_DEC_DONE;
								end
							end
						end
					end
					DDCM_DEC_ACK: begin
						if (scl_fall) begin
							if (!ack_reg) begin
								ack_next = 1'b1;
							end else begin
								ack_next = 1'b0;
								dec_next = DDCM_DEC_DONE;
							end
						end
					end
					DDCM_DEC_IDLE,
					DDCM_DEC_DONE: begin
						dec_next = dec_reg;
					end
					default: begin
						dec_next = DDCM_DEC_IDLE;
					end
				endcase
			end
		end else begin
			dec_next = DDCM_DEC_IDLE;
			ack_next = 1'b0;
		end

		case (mode_reg)
			DDCM_TXO: begin
				if (scl_fall) begin
					mode_next     = P_RECOVERY_EN ? DDCM_TRANS : DDCM_LOCK;
					pulse_next    = '0;
					timer_next    = '0;
					txo_pull_next = 1'b0;
				end else if (transmit_only_clock_rise && scl_s) begin
					if (init_reg != INIT_CNT_LAST) begin
						init_next     = init_reg + 4'h1;
						txo_pull_next = 1'b0;
					end
					if (init_reg == INIT_CNT_LAST) begin
						if (bit_reg == IDX_ZERO) begin
							byte_next     = i_rd_data;
							txo_pull_next = ~i_rd_data[DATA_W-1];
							bit_next      = 4'h1;
						end else if (bit_reg == BIT_IDX_DONTCARE) begin
							txo_pull_next = 1'b0;
							bit_next      = IDX_ZERO;
						end else begin
							txo_pull_next = ~byte_reg[3'(BIT_IDX_LAST - bit_reg)];
							bit_next      = bit_reg + 4'h1;
							if (bit_reg == BIT_IDX_LAST) begin
								addr_next = addr_reg + 7'h01;
							end
						end
					end
				end
			end
			DDCM_TRANS: begin
				if (scl_fall) begin
					pulse_next = '0;
					timer_next = '0;
				end else begin
					timer_next = timer_reg + 32'h0000_0001;
					if (transmit_only_clock_rise) begin
						pulse_next = pulse_reg + 8'h01;
					end
					if ((transmit_only_clock_rise && pulse_reg == PULSE_LAST)
					    || timer_reg == P_RECOVERY_CYCLES - 32'h0000_0001) begin
						revert = 1'b1;
					end
				end
				if (sel_next) begin
					mode_next = DDCM_LOCK;
				end else if (revert) begin
					mode_next     = DDCM_TXO;
					init_next     = IDX_ZERO;
					bit_next      = IDX_ZERO;
					addr_next     = ADDR_RESET;
					txo_pull_next = 1'b0;
				end
			end
			DDCM_LOCK: begin
				// Stays here until reset; pulses not counted
				mode_next = DDCM_LOCK;
			end
			default: begin
				mode_next = DDCM_TXO;
			end
		endcase

		if (mode_next != DDCM_TRANS) begin
			timer_next = '0;
			pulse_next = '0;
		end

		pull_next = (mode_reg == DDCM_TXO) ? txo_pull_next
		            : (ack_next | i_engine_pull_low);
		wen_next  = (mode_next != DDCM_TXO) && (P_HAS_WP_PIN ? wp_s : transmit_only_clock_s);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_reg     <= DDCM_TXO;
			dec_reg      <= DDCM_DEC_IDLE;
			pulse_reg    <= '0;
			timer_reg    <= '0;
			init_reg     <= IDX_ZERO;
			bit_reg      <= IDX_ZERO;
			addr_reg     <= ADDR_RESET;
			byte_reg     <= '0;
			txo_pull_reg <= 1'b0;
			sr_reg       <= '0;
			dbit_reg     <= IDX_ZERO;
			ack_reg      <= 1'b0;
			sel_reg      <= 1'b0;
			rw_reg       <= 1'b0;
			pull_reg     <= 1'b0;
			wen_reg      <= 1'b0;
		end else begin
			mode_reg     <= mode_next;
			dec_reg      <= dec_next;
			pulse_reg    <= pulse_next;
			timer_reg    <= timer_next;
			init_reg     <= init_next;
			bit_reg      <= bit_next;
			addr_reg     <= addr_next;
			byte_reg     <= byte_next;
			txo_pull_reg <= txo_pull_next;
			sr_reg       <= sr_next;
			dbit_reg     <= dbit_next;
			ack_reg      <= ack_next;
			sel_reg      <= sel_next;
			rw_reg       <= rw_next;
			pull_reg     <= pull_next;
			wen_reg      <= wen_next;
		end
	end

	assign o_rd_addr       = addr_reg;
	assign o_sda_out       = 1'b0;
	assign o_sda_oe_n      = ~pull_reg;
	assign o_two_wire_mode = two_wire;
	assign o_locked        = (mode_reg == DDCM_LOCK);
	assign o_write_enable  = wen_reg;
	assign o_select_pulse  = sel_reg;
	assign o_select_rw     = rw_reg;

endmodule : ddcm_mode_ctrl

// *** testbench/ddcm_checker.sv ***
// Port assertions for the mode recovery control block
`timescale 1ns/1ps
module ddcm_checker
	import ddcm_pkg::*;
(
	input wire logic              i_ref_clk,
	input wire logic              i_rst,
	input wire logic              i_scl,
	input wire logic [ADDR_W-1:0] o_rd_addr,
	input wire logic              o_sda_out,
	input wire logic              o_sda_oe_n,
	input wire logic              o_two_wire_mode,
	input wire logic              o_locked,
	input wire logic              o_write_enable,
	input wire logic              o_select_pulse
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	chk_sda_drain: assert property (o_sda_out == 1'b0)
		else $error("sda output not low");
	chk_lock_two: assert property (o_locked |-> o_two_wire_mode)
		else $error("lock outside two-wire mode");
	chk_lock_stays: assert property (o_locked |=> o_locked)
		else $error("lock dropped");
	chk_sel_lock: assert property (o_select_pulse |-> o_locked)
		else $error("select without lock");
	chk_sel_single: assert property (o_select_pulse |=> !o_select_pulse)
		else $error("select pulse too long");
	chk_we_mode: assert property (o_write_enable |-> o_two_wire_mode)
		else $error("write enable in transmit-only mode");
	chk_lock_addr: assert property (o_locked && $past(o_locked) |-> $stable(o_rd_addr))
		else $error("address moved while locked");
	chk_mode_scl: assert property ($rose(o_two_wire_mode) |-> !$past(i_scl, 2))
		else $error("mode change without scl low");
	chk_revert_addr: assert property ($fell(o_two_wire_mode) |-> ##[0:1] o_rd_addr == ADDR_RESET)
		else $error("revert kept address");
	cov_select: cover property (o_select_pulse);
	cov_revert: cover property ($fell(o_two_wire_mode));
	cov_ack: cover property (o_two_wire_mode && !o_sda_oe_n);
endmodule : ddcm_checker
bind ddcm_mode_ctrl ddcm_checker u_chk (
	.i_ref_clk      (i_ref_clk),
	.i_rst          (i_rst),
	.i_scl          (i_scl),
	.o_rd_addr      (o_rd_addr),
	.o_sda_out      (o_sda_out),
	.o_sda_oe_n     (o_sda_oe_n),
	.o_two_wire_mode(o_two_wire_mode),
	.o_locked       (o_locked),
	.o_write_enable (o_write_enable),
	.o_select_pulse (o_select_pulse)
);

// *** testbench/ddcm_host.sv ***
// Bus master model driving serial clock, transmit-only clock and data
`timescale 1ns/1ps
module ddcm_host (
	input  wire logic i_ref_clk,
	input  wire logic i_sda_oe_n,
	output logic      o_scl,
	output logic      o_txo_clk,
	output wire logic o_sda
);
	logic drv_n = 1'b1;
	initial o_scl = 1'b1;
	initial o_txo_clk = 1'b0;
	// Pull-up wire shared with the device
	assign o_sda = drv_n & i_sda_oe_n;
	task automatic wt(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask : wt
	task automatic txo_pulses(input int n);
		repeat (n) begin
			o_txo_clk = 1'b1;
			wt(4);
			o_txo_clk = 1'b0;
			wt(4);
		end
	endtask : txo_pulses
	task automatic txo_level(input logic v);
		o_txo_clk = v;
		wt(8);
	endtask : txo_level
	task automatic scl_tog();
		o_scl = 1'b0;
		wt(8);
		o_scl = 1'b1;
		wt(8);
	endtask : scl_tog
	// Enter two-wire, START, one byte, sample ack, STOP
	task automatic sel(input logic [7:0] b, output logic a);
		scl_tog();
		drv_n = 1'b0;
		wt(8);
		o_scl = 1'b0;
		wt(4);
		for (int i = 7; i >= 0; i--) begin
			drv_n = b[i];
			wt(4);
			o_scl = 1'b1;
			wt(8);
			o_scl = 1'b0;
			wt(4);
		end
		drv_n = 1'b1;
		wt(8);
		o_scl = 1'b1;
		wt(4);
		a = o_sda;
		wt(4);
		o_scl = 1'b0;
		drv_n = 1'b0;
		wt(8);
		o_scl = 1'b1;
		wt(8);
		drv_n = 1'b1;
		wt(8);
	endtask : sel
endmodule : ddcm_host

// *** testbench/tb_ddcm_mode_ctrl.sv ***
// Self-checking bench for the mode recovery control block
`timescale 1ns/1ps
module tb_ddcm_mode_ctrl
	import ddcm_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              scl, txo_clk, sda, oe_n, two, lck, we, rw;
	logic              sdo, sp, oe2, two2, lck2, we2, sp2, rw2, sdo2;
	logic              wp = 1'b0;
	logic              epl = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] addr2;
	int                sel_cnt = 0;
	logic [DATA_W-1:0] rd;
	int                error_cnt = 0;
	int                check_count = 0;
	// Select byte, expected ack level, lock, rw
	logic [10:0]       rows [3] = '{{8'h3A, 3'b100}, {8'h5B, 3'b011}, {8'h54, 3'b010}};
	always #20 clk = ~clk;
	assign rd = {addr[0], addr} ^ 8'h3C;
	always @(negedge clk) sel_cnt = sel_cnt + int'(sp) + int'(sp2);
	ddcm_mode_ctrl #(.P_RECOVERY_CYCLES(TIMER_W'(2000))) DUT (
		.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_in(sda),
		.i_transmit_only_clock(txo_clk), .i_write_protect_input(wp),
		.i_rd_data(rd), .i_engine_pull_low(epl), .o_rd_addr(addr),
		.o_sda_out(sdo), .o_sda_oe_n(oe_n), .o_two_wire_mode(two), .o_locked(lck),
		.o_write_enable(we), .o_select_pulse(sp), .o_select_rw(rw));
	// Write-protect pin variant on the same wires
	ddcm_mode_ctrl #(.P_RECOVERY_CYCLES(TIMER_W'(2000)), .P_HAS_WP_PIN(1'b1)) DUT_WP (
		.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_in(sda),
		.i_transmit_only_clock(txo_clk), .i_write_protect_input(wp),
		.i_rd_data(rd), .i_engine_pull_low(epl), .o_rd_addr(addr2),
		.o_sda_out(sdo2), .o_sda_oe_n(oe2), .o_two_wire_mode(two2), .o_locked(lck2),
		.o_write_enable(we2), .o_select_pulse(sp2), .o_select_rw(rw2));
	ddcm_host u_host (.i_ref_clk(clk), .i_sda_oe_n(oe_n), .o_scl(scl),
		.o_txo_clk(txo_clk), .o_sda(sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	initial begin
		logic       a;
		logic [7:0] e;
		int         k;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk({oe_n, two, lck, we, oe2, two2, lck2, we2}, 8'h88);
		chk(8'(addr), 8'h00);
		for (k = 1; k <= 27; k++) begin
			u_host.txo_pulses(1);
			e = {1'((k - 10) / 9), 7'((k - 10) / 9)} ^ 8'h3C;
			chk(8'(oe_n), (k < 10 || (k - 10) % 9 == 8) ? 8'h01 : 8'(e[7 - (k - 10) % 9]));
		end
		chk(8'(addr), 8'h02);
		u_host.scl_tog();
		chk(8'(two), 8'h01);
		u_host.txo_pulses(127);
		u_host.scl_tog();
		u_host.txo_pulses(127);
		chk(8'(two), 8'h01);
		u_host.txo_pulses(1);
		chk({two, addr}, 8'h00);
		u_host.scl_tog();
		repeat (1880) @(negedge clk);
		chk(8'(two), 8'h01);
		repeat (200) @(negedge clk);
		chk(8'(two), 8'h00);
		for (k = 0; k < 3; k++) begin
			u_host.sel(rows[k][10:3], a);
			chk(8'({a, lck}), 8'(rows[k][2:1]));
			if (rows[k][1])
				chk(8'({rw, rw2}), 8'({2{rows[k][0]}}));
		end
		chk(8'(sel_cnt), 8'h04);
		u_host.txo_level(1'b1);
		chk({we, two, oe_n, we2, two2, lck2, 2'h0}, 8'hEC);
		wp = 1'b1;
		u_host.txo_level(1'b0);
		chk({we, we2, 6'h0}, 8'h40);
		u_host.txo_pulses(140);
		chk({two, addr}, 8'h80);
		chk({two2, addr2}, 8'h80);
		epl = 1'b1;
		repeat (2) @(negedge clk);
		chk({oe_n, oe2, sdo, sdo2, 4'h0}, 8'h00);
		epl = 1'b0;
		repeat (4) @(negedge clk);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk(8'({two, lck}), 8'h00);
		epl = 1'b1;
		repeat (2) @(negedge clk);
		chk({two, lck, oe_n, oe2, 4'h0}, 8'h30);
		epl = 1'b0;
		close_out();
	end
	initial begin
		#1_000_000;
		error_cnt++;
		close_out();
	end
endmodule : tb_ddcm_mode_ctrl
